// *** design/mode_reg_mem.sv ***
// Purpose: Four mode registers with a registered read port
// Assumes: Single clock, reset already synchronised
// Notes: Write and read of the same word in one cycle returns the old word
`timescale 1ns/100ps
`default_nettype none
`include "sdram_cmd_defs.svh"
module mode_reg_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write side
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire logic [`ADDR_W-1:0] wr_data,
    // Read side
    input wire logic [1:0] rd_sel,
    output logic [`ADDR_W-1:0] rd_data
);
    logic [`ADDR_W-1:0] mem_r [4];

    // Storage cleared to a known mode at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                mem_r[i] <= `MR0_RESET;
            end
        end else if (wr_en) begin
            mem_r[wr_sel] <= wr_data;
        end
    end

    // Registered read keeps the top outputs flop-driven
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= `MR0_RESET;
        end else begin
            rd_data <= mem_r[rd_sel];
        end
    end
endmodule
`default_nettype wire

// *** design/sdram_cmd_defs.svh ***
// Purpose: Offsets, field positions, reset values and cycle counts of the command decoder
// Assumes: 200 MHz ref_clk
// Notes: Definitions only
`ifndef SDRAM_CMD_DEFS_SVH
`define SDRAM_CMD_DEFS_SVH

// Address line positions
`define ADDR_AP_BIT 10
`define ADDR_BL_BIT 12
`define ADDR_W 16
`define BANK_W 3
`define BANKS 8
`define DM_W 2

// Row field top bit per organisation
`define ROW_MSB_NARROW 4'hf
`define ROW_MSB_WIDE 4'he
`define COL_MSB 4'h9

// Burst-length field of mode register 0
`define MR0_BL_LSB 0
`define MR0_BL_FIXED8 2'h0
`define MR0_BL_OTF 2'h1
`define MR0_BL_FIXED4 2'h2
`define MR0_RESET 16'h0000

// Burst durations in clocks
`define BURST8_CYCLES 3'h4
`define CHOP4_CYCLES 3'h2

// Internal busy windows
`define EXIT_NS 20
`define REFRESH_NS 160
`define CLK_NS 5
`define EXIT_CYCLES (((`EXIT_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define REFRESH_CYCLES (((`REFRESH_NS) + (`CLK_NS) - 1) / (`CLK_NS))

`endif

// *** design/sdram_cmd_pkg.sv ***
// Purpose: Types shared by the command decoder files
// Assumes: sdram_cmd_defs.svh
// Notes: Types only
`include "sdram_cmd_defs.svh"
package sdram_cmd_pkg;
    // Controller pin bundle sampled each edge
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic [`BANK_W-1:0] ba;
        logic [`ADDR_W-1:0] addr;
        logic [`DM_W-1:0] dm;
    } cmd_pins_type;

    typedef enum logic [3:0] {
        CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ, CMD_NOP, CMD_DES
    } cmd_type;

    typedef enum logic [1:0] {
        PWR_ACTIVE, PWR_ACT_PD, PWR_PRE_PD, PWR_SELF_REF
    } pwr_state_type;
endpackage

// *** design/sdram_command_decode.sv ***
// Purpose: Command decode and clock-enable state logic of a DDR3L SDRAM die
// Assumes: Command pins arrive from the controller, sampled on ref_clk at 200 MHz
// Notes: Data path and per-command timing are outside this block
// Contract
// - Decode command from strobes and CKE each edge
// - Chip select high is deselect, acts as nop
// - No-operation registers nothing, ends nothing
// - Strobe combinations map to the eight commands
// - Bank address selects bank; A10 precharges all
// - Mode set: bank picks one of four
// - A10 auto precharge; A12 chop when OTF
// - Bursts run to completion, never interrupted
// - ZQ long or short by A10; init variant first
// - Reset is active low and asynchronous
// - On-die termination input affects nothing here
// - Self refresh exits on CKE rise with nop
// - No own refresh while in power-down
// - Idle means banks closed, no burst, settled
// - CKE low-low holds, low-high with nop exits
// - CKE fall enters active, precharge PD or self refresh
// - Row field top bit follows the organisation
// - Masked write bytes are not stored
`timescale 1ns/100ps
`default_nettype none
`include "sdram_cmd_defs.svh"
module sdram_command_decode (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Controller command pins
    input wire sdram_cmd_pkg::cmd_pins_type pins,
    input wire logic odt,
    // Configuration
    input wire logic org_wide,
    input wire logic [1:0] mr_rd_sel,
    // Bank and burst state
    output logic [`BANKS-1:0] bank_open,
    output logic burst_active,
    output logic burst_write,
    output logic burst_len8,
    output logic burst_auto_pre,
    output logic [`BANK_W-1:0] burst_bank,
    output logic [`ADDR_W-1:0] col_addr,
    output logic [`ADDR_W-1:0] act_row,
    output logic [`DM_W-1:0] byte_we,
    // Power state
    output sdram_cmd_pkg::pwr_state_type pwr_state,
    output logic idle,
    // Command events
    output sdram_cmd_pkg::cmd_type last_cmd,
    output logic refresh_pulse,
    output logic mrs_pulse,
    output logic zq_init_pulse,
    output logic zq_oper_pulse,
    output logic zq_short_pulse,
    output logic [`ADDR_W-1:0] mr_rd_data
);
    // Reset release through two flops; the pin still clears everything at once
    logic rst_meta_r, rst_n_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // Pin bundle passes three flops; a new value counts once stages two and three agree
    sdram_cmd_pkg::cmd_pins_type s1_r, s2_r, s3_r, cur_r;
    logic cke_prev_r;
    // Strobes read inactive while the late stages disagree, so a command held for two
    // cycles acts once; other lines keep their last agreed level through address noise
    wire sdram_cmd_pkg::cmd_pins_type strobe_mask = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
        we_n: 1'b1, default: '0};
    wire [$bits(sdram_cmd_pkg::cmd_pins_type)-1:0] agree = ~(s2_r ^ s3_r);
    wire sdram_cmd_pkg::cmd_pins_type cur_nxt = (agree & s3_r) | (~agree & strobe_mask)
        | (~agree & ~strobe_mask & cur_r);
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            s1_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            s2_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            s3_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            cur_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            cke_prev_r <= 1'b0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            cur_r <= cur_nxt;
            cke_prev_r <= cur_r.cke;
        end
    end

    // Strobe decode; cs_n high overrides every other pin
    function automatic sdram_cmd_pkg::cmd_type decode_cmd(input sdram_cmd_pkg::cmd_pins_type p);
        logic [2:0] s;
        s = {p.ras_n, p.cas_n, p.we_n};
        if (p.cs_n) begin
            decode_cmd = sdram_cmd_pkg::CMD_DES;
        end else begin
            case (s)
                3'h0: decode_cmd = sdram_cmd_pkg::CMD_MRS;
                3'h1: decode_cmd = sdram_cmd_pkg::CMD_REF;
                3'h2: decode_cmd = sdram_cmd_pkg::CMD_PRE;
                3'h3: decode_cmd = sdram_cmd_pkg::CMD_ACT;
                3'h4: decode_cmd = sdram_cmd_pkg::CMD_WR;
                3'h5: decode_cmd = sdram_cmd_pkg::CMD_RD;
                3'h6: decode_cmd = sdram_cmd_pkg::CMD_ZQ;
                default: decode_cmd = sdram_cmd_pkg::CMD_NOP;
            endcase
        end
    endfunction

    // State registers
    sdram_cmd_pkg::pwr_state_type pwr_r, pwr_nxt;
    logic [`BANKS-1:0] open_r;
    wire [`BANKS-1:0] open_nxt;
    logic burst_r;
    logic [2:0] burst_cnt_r;
    logic [7:0] exit_cnt_r, ref_cnt_r;
    logic [1:0] mr0_bl_r;
    logic zq_done_r;

    // The odt pin is deliberately left out of every decode term
    wire odt_unused = odt;
    wire sdram_cmd_pkg::cmd_type cmd = decode_cmd(cur_r);
    wire nop_like = (cmd == sdram_cmd_pkg::CMD_DES) || (cmd == sdram_cmd_pkg::CMD_NOP);
    wire cke_hh = cke_prev_r && cur_r.cke;
    wire cke_hl = cke_prev_r && !cur_r.cke;
    wire cke_lh = !cke_prev_r && cur_r.cke;
    wire live = cke_hh && (pwr_r == sdram_cmd_pkg::PWR_ACTIVE);
    wire a10 = cur_r.addr[`ADDR_AP_BIT];
    wire [`BANK_W-1:0] ba = cur_r.ba;
    wire is_mrs = live && (cmd == sdram_cmd_pkg::CMD_MRS);
    wire is_ref = live && (cmd == sdram_cmd_pkg::CMD_REF);
    wire is_pre = live && (cmd == sdram_cmd_pkg::CMD_PRE);
    wire is_act = live && (cmd == sdram_cmd_pkg::CMD_ACT);
    wire is_zq = live && (cmd == sdram_cmd_pkg::CMD_ZQ);
    // A burst in flight refuses a new column command rather than being cut short
    wire rw_cmd = live && ((cmd == sdram_cmd_pkg::CMD_RD) || (cmd == sdram_cmd_pkg::CMD_WR));
    wire rw_go = rw_cmd && !burst_r && open_r[ba];
    wire otf_en = (mr0_bl_r == `MR0_BL_OTF);
    wire len8 = otf_en ? cur_r.addr[`ADDR_BL_BIT] : (mr0_bl_r != `MR0_BL_FIXED4);
    wire burst_end = burst_r && (burst_cnt_r == 3'h1);
    wire ap_close = burst_end && burst_auto_pre;
    // Settled leaves out the present clock enable, so self refresh entry can use it
    wire settled = (open_r == '0) && !burst_r && (exit_cnt_r == 8'h0)
        && (ref_cnt_r == 8'h0) && (pwr_r == sdram_cmd_pkg::PWR_ACTIVE);
    wire idle_now = settled && cur_r.cke;
    wire [3:0] row_msb = org_wide ? `ROW_MSB_WIDE : `ROW_MSB_NARROW;
    wire [`ADDR_W-1:0] row_mask = 16'hffff >> (4'hf - row_msb);
    wire [`ADDR_W-1:0] col_mask = 16'hffff >> (4'hf - `COL_MSB);

    // Per-bank open flags: activate opens, precharge or auto precharge closes
    genvar gb;
    generate
        for (gb = 0; gb < `BANKS; gb++) begin : g_bank
            wire hit = (ba == 3'(gb));
            wire pre_hit = is_pre && (a10 || hit);
            wire ap_hit = ap_close && (burst_bank == 3'(gb));
            assign open_nxt[gb] = (open_r[gb] || (is_act && hit)) && !pre_hit && !ap_hit;
        end
    endgenerate

    // Clock-enable state machine
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            sdram_cmd_pkg::PWR_ACTIVE: begin
                if (cke_hl && nop_like) begin
                    pwr_nxt = (open_r != '0) ? sdram_cmd_pkg::PWR_ACT_PD
                        : sdram_cmd_pkg::PWR_PRE_PD;
                end else if (cke_hl && (cmd == sdram_cmd_pkg::CMD_REF) && settled) begin
                    pwr_nxt = sdram_cmd_pkg::PWR_SELF_REF;
                end
            end
            sdram_cmd_pkg::PWR_ACT_PD, sdram_cmd_pkg::PWR_PRE_PD: begin
                if (cke_lh && nop_like) begin
                    pwr_nxt = sdram_cmd_pkg::PWR_ACTIVE;
                end
            end
            sdram_cmd_pkg::PWR_SELF_REF: begin
                if (cke_lh && nop_like) begin
                    pwr_nxt = sdram_cmd_pkg::PWR_ACTIVE;
                end
            end
            default: pwr_nxt = sdram_cmd_pkg::PWR_ACTIVE;
        endcase
    end

    // Power state, banks and exit settling
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pwr_r <= sdram_cmd_pkg::PWR_ACTIVE;
            open_r <= '0;
            exit_cnt_r <= 8'h0;
            idle <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            open_r <= open_nxt;
            if ((pwr_r != sdram_cmd_pkg::PWR_ACTIVE) && (pwr_nxt == sdram_cmd_pkg::PWR_ACTIVE)) begin
                exit_cnt_r <= 8'(`EXIT_CYCLES);
            end else if (exit_cnt_r != 8'h0) begin
                exit_cnt_r <= exit_cnt_r - 8'h1;
            end
            idle <= idle_now;
        end
    end

    // Burst tracker; runs off its own counter so nothing can cut it
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            burst_r <= 1'b0;
            burst_cnt_r <= 3'h0;
            burst_write <= 1'b0;
            burst_len8 <= 1'b0;
            burst_auto_pre <= 1'b0;
            burst_bank <= '0;
            col_addr <= '0;
        end else if (rw_go) begin
            burst_r <= 1'b1;
            burst_cnt_r <= len8 ? `BURST8_CYCLES : `CHOP4_CYCLES;
            burst_write <= (cmd == sdram_cmd_pkg::CMD_WR);
            burst_len8 <= len8;
            burst_auto_pre <= a10;
            burst_bank <= ba;
            col_addr <= cur_r.addr & col_mask;
        end else if (burst_r) begin
            burst_cnt_r <= burst_cnt_r - 3'h1;
            burst_r <= !burst_end;
        end
    end
    assign burst_active = burst_r;

    // Write byte enables: a mask bit high keeps that byte out of the array
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            byte_we <= '0;
        end else begin
            byte_we <= (burst_r && burst_write) ? ~cur_r.dm : '0;
        end
    end

    // Command events, activate row and refresh busy window
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            last_cmd <= sdram_cmd_pkg::CMD_DES;
            refresh_pulse <= 1'b0;
            mrs_pulse <= 1'b0;
            zq_init_pulse <= 1'b0;
            zq_oper_pulse <= 1'b0;
            zq_short_pulse <= 1'b0;
            zq_done_r <= 1'b0;
            act_row <= '0;
            ref_cnt_r <= 8'h0;
            mr0_bl_r <= `MR0_BL_FIXED8;
        end else begin
            last_cmd <= live ? cmd : sdram_cmd_pkg::CMD_DES;
            refresh_pulse <= is_ref;
            mrs_pulse <= is_mrs;
            zq_init_pulse <= is_zq && a10 && !zq_done_r;
            zq_oper_pulse <= is_zq && a10 && zq_done_r;
            zq_short_pulse <= is_zq && !a10;
            if (is_zq && a10) begin
                zq_done_r <= 1'b1;
            end
            if (is_act) begin
                act_row <= cur_r.addr & row_mask;
            end
            if (is_ref) begin
                ref_cnt_r <= 8'(`REFRESH_CYCLES);
            end else if (ref_cnt_r != 8'h0) begin
                ref_cnt_r <= ref_cnt_r - 8'h1;
            end
            if (is_mrs && (ba[1:0] == 2'h0)) begin
                mr0_bl_r <= cur_r.addr[`MR0_BL_LSB +: 2];
            end
        end
    end
    assign bank_open = open_r;
    assign pwr_state = pwr_r;

    // Mode register storage, one of four words chosen by the low bank bits
    mode_reg_mem u_mode_regs (
        .clk(ref_clk),
        .rst_n(rst_n_r),
        .wr_en(is_mrs),
        .wr_sel(ba[1:0]),
        .wr_data(cur_r.addr),
        .rd_sel(mr_rd_sel),
        .rd_data(mr_rd_data)
    );

    // Checks
    chk_desel_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        cur_r.cs_n |=> !refresh_pulse && !mrs_pulse && !zq_short_pulse)
        else $error("deselect produced a command event");
    chk_nop_keeps_burst: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        (burst_r && burst_cnt_r > 3'h1 && nop_like) |=> burst_r)
        else $error("nop ended a burst");
    chk_ref_decode: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        (live && !cur_r.cs_n && !cur_r.ras_n && !cur_r.cas_n && cur_r.we_n) |=> refresh_pulse)
        else $error("refresh not decoded");
    chk_prea_all: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        (is_pre && a10) |=> (open_r == '0))
        else $error("precharge all left a bank open");
    chk_act_opens: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        is_act |=> open_r[$past(ba)])
        else $error("activate did not open bank");
    chk_burst_length: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        (rw_go && len8) |=> burst_r [*4] ##1 !burst_r)
        else $error("eight-beat burst wrong length");
    chk_zq_variant: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        (is_zq && a10) |=> (zq_init_pulse != zq_oper_pulse) && (zq_init_pulse == !$past(zq_done_r)))
        else $error("wrong long calibration variant");
    chk_sr_exit: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        (pwr_r == sdram_cmd_pkg::PWR_SELF_REF && cke_lh && nop_like)
        |=> pwr_r == sdram_cmd_pkg::PWR_ACTIVE ##1 exit_cnt_r != 8'h0)
        else $error("self refresh exit missed");
    chk_pd_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        (pwr_r != sdram_cmd_pkg::PWR_ACTIVE && !cke_prev_r && !cur_r.cke) |=> $stable(pwr_r))
        else $error("low clock enable left power state");
    chk_pd_norefresh: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        (pwr_r != sdram_cmd_pkg::PWR_ACTIVE) |=> !refresh_pulse)
        else $error("refresh event in power-down");
    chk_pd_entry: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        (pwr_r == sdram_cmd_pkg::PWR_ACTIVE && cke_hl && nop_like && open_r != '0)
        |=> pwr_r == sdram_cmd_pkg::PWR_ACT_PD)
        else $error("active power-down not entered");
    chk_idle_meaning: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        idle |-> ($past(open_r) == '0) && !$past(burst_r) && $past(exit_cnt_r) == 8'h0)
        else $error("idle while busy");
    chk_mask_bytes: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
        (burst_r && burst_write) |=> (byte_we & $past(cur_r.dm)) == '0)
        else $error("masked byte enabled");
    cov_write_burst: cover property (@(posedge ref_clk) disable iff (!rst_n_r)
        rw_go && cmd == sdram_cmd_pkg::CMD_WR ##1 burst_r [*2]);
    cov_self_ref: cover property (@(posedge ref_clk) disable iff (!rst_n_r)
        pwr_r == sdram_cmd_pkg::PWR_SELF_REF ##1 pwr_r == sdram_cmd_pkg::PWR_ACTIVE);
    cov_act_pd: cover property (@(posedge ref_clk) disable iff (!rst_n_r)
        pwr_r == sdram_cmd_pkg::PWR_ACT_PD);
endmodule
`default_nettype wire

// *** tb/sdram_command_decode_tb.sv ***
// Purpose: Self-checking bench of the command decoder against a bench model
// Assumes: 200 MHz ref_clk, controller model drives the pins
// Notes: Event counts are taken over a fixed window after every command
`timescale 1ns/100ps
`default_nettype none
module sdram_command_decode_tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic odt = 1'b0;
    logic org_wide = 1'b0;
    logic [1:0] mr_rd_sel = 2'h0;
    sdram_cmd_pkg::cmd_pins_type pins;
    logic [7:0] bank_open;
    logic burst_active, burst_write, burst_len8, burst_auto_pre;
    logic [2:0] burst_bank;
    logic [15:0] col_addr, act_row, mr_rd_data;
    logic [1:0] byte_we, we_seen;
    logic [3:0] lc_seen;
    sdram_cmd_pkg::pwr_state_type pwr_state;
    sdram_cmd_pkg::cmd_type last_cmd;
    logic idle, ref_p, mrs_p, zi_p, zo_p, zs_p;
    wire [5:0] ev = {ref_p, mrs_p, zi_p, zo_p, zs_p, burst_active};
    int errors = 0;
    int checks_done = 0;
    integer seed = 32'hc04c931e;
    int cnt [6];
    logic [7:0] m_open = 8'h00;
    logic [15:0] m_mr [4];
    logic zq_done = 1'b0;
    logic [2:0] b;

    // Clock
    always #2.5 ref_clk = ~ref_clk;

    sdram_command_decode dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .pins(pins), .odt(odt),
        .org_wide(org_wide), .mr_rd_sel(mr_rd_sel), .bank_open(bank_open),
        .burst_active(burst_active), .burst_write(burst_write), .burst_len8(burst_len8),
        .burst_auto_pre(burst_auto_pre), .burst_bank(burst_bank), .col_addr(col_addr),
        .act_row(act_row),
        .byte_we(byte_we), .pwr_state(pwr_state), .idle(idle), .last_cmd(last_cmd),
        .refresh_pulse(ref_p), .mrs_pulse(mrs_p), .zq_init_pulse(zi_p),
        .zq_oper_pulse(zo_p), .zq_short_pulse(zs_p), .mr_rd_data(mr_rd_data));
    sdram_ctrl_model ctl_u (.ref_clk(ref_clk), .pins(pins));

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("Checks: %0d errors: %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Count event cycles and enabled bytes over a window
    task automatic watch(input int n);
        cnt = '{default: 0};
        we_seen = 2'h0;
        lc_seen = 4'(sdram_cmd_pkg::CMD_NOP);
        repeat (n) begin
            @(negedge ref_clk);
            for (int i = 0; i < 6; i++) cnt[i] += ev[i];
            we_seen |= byte_we;
            if (last_cmd < sdram_cmd_pkg::CMD_NOP) lc_seen = last_cmd;
        end
    endtask

    // Model one command with clock enable high, send it, compare every result
    task automatic do_cmd(input logic [3:0] c, input logic [2:0] ba, input logic [15:0] a,
                          input logic [1:0] dm);
        int e [6];
        logic [1:0] e_we;
        logic hit;
        e = '{default: 0};
        e_we = 2'h0;
        hit = 1'b0;
        odt = 1'($random(seed));
        org_wide = 1'($random(seed));
        case (c)
            4'h0: begin
                m_mr[ba[1:0]] = a;
                e[4] = 1;
            end
            4'h1: e[5] = 1;
            4'h2: m_open = a[10] ? 8'h00 : m_open & ~(8'h01 << ba);
            4'h3: m_open[ba] = 1'b1;
            4'h4, 4'h5: begin
                hit = m_open[ba];
                e[0] = !hit ? 0 : m_mr[0][1:0] == 2'h0 ? 4 : m_mr[0][1:0] == 2'h2 ? 2 : a[12] ? 4 : 2;
                e_we = (hit && !c[0]) ? ~dm : 2'h0;
                m_open[ba] = m_open[ba] & !(hit && a[10]);
            end
            4'h6: begin
                e[3] = a[10] && !zq_done;
                e[2] = a[10] && zq_done;
                e[1] = !a[10];
                zq_done = zq_done | a[10];
            end
            default: ;
        endcase
        ctl_u.send(c, 1'b1, ba, a, dm);
        watch(14);
        foreach (e[i]) check(cnt[i], e[i], "event cycles");
        check(bank_open, m_open, "open banks");
        check(we_seen, e_we, "byte enables");
        if (c == 4'h3) check(act_row, org_wide ? a & 16'h7fff : a, "row");
        if (hit) check({burst_len8, burst_write, burst_bank}, {e[0] == 4, !c[0], ba}, "burst");
        if (hit) check(col_addr, a & 16'h03ff, "column");
        if (hit) check(burst_auto_pre, a[10], "auto precharge");
        check(lc_seen, c[3] ? 4'(sdram_cmd_pkg::CMD_NOP) : c, "last command");
    endtask

    // Power transition and its resulting state
    task automatic pd(input logic [3:0] c, input logic cke, input sdram_cmd_pkg::pwr_state_type s);
        ctl_u.send(c, cke, 3'h0, 16'h0000, 2'h0);
        watch(14);
        check(pwr_state, s, "power state");
    endtask

    // Main sequence
    initial begin
        foreach (m_mr[i]) m_mr[i] = 16'h0000;
        repeat (5) @(negedge ref_clk);
        check({bank_open, pwr_state}, {8'h00, sdram_cmd_pkg::PWR_ACTIVE}, "reset");
        check(last_cmd, sdram_cmd_pkg::CMD_DES, "reset cmd");
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        for (int i = 0; i < 4; i++) do_cmd(4'h0, {1'($random(seed)), 2'(i)}, 16'($random(seed)) & 16'hfffc, 2'h0);
        for (int i = 0; i < 4; i++) begin
            mr_rd_sel = 2'(i);
            repeat (3) @(negedge ref_clk);
            check(mr_rd_data, m_mr[i], "mode register");
        end
        for (int i = 0; i < 8; i++) do_cmd(4'h3, 3'(i), 16'($random(seed)), 2'h0);
        for (int s = 0; s < 8; s++) do_cmd({1'b1, 3'(s)}, 3'h0, 16'h0400, 2'h0);
        do_cmd(4'h7, 3'h0, 16'h0400, 2'h0);
        do_cmd(4'h2, 3'h5, 16'h0000, 2'h0);
        // Every burst mode, both directions, random auto precharge
        for (int m = 0; m < 3; m++) begin
            do_cmd(4'h2, 3'h0, 16'h0400, 2'h0);
            do_cmd(4'h0, 3'h0, {14'h0000, 2'(m)}, 2'h0);
            for (int k = 0; k < 4; k++) begin
                b = 3'($random(seed));
                if (!m_open[b]) do_cmd(4'h3, b, 16'($random(seed)), 2'h0);
                do_cmd({3'h2, k[0]}, b, {3'h0, k[1], 12'($random(seed))}, 2'($random(seed)));
            end
        end
        do_cmd(4'h2, 3'h0, 16'h0400, 2'h0);
        do_cmd(4'h5, 3'h2, 16'h0000, 2'h0);
        do_cmd(4'h1, 3'h0, 16'h0000, 2'h0);
        for (int z = 0; z < 3; z++) do_cmd(4'h6, 3'h0, {5'h00, z != 1, 10'h000}, 2'h0);
        repeat (40) @(negedge ref_clk);
        check(idle, 1'b1, "idle");
        do_cmd(4'h3, 3'h6, 16'h0123, 2'h0);
        check(idle, 1'b0, "idle with open bank");
        pd(4'h7, 1'b0, sdram_cmd_pkg::PWR_ACT_PD);
        ctl_u.send(4'h1, 1'b0, 3'h0, 16'h0000, 2'h0);
        watch(14);
        check(cnt[5], 0, "refresh in power-down");
        check(pwr_state, sdram_cmd_pkg::PWR_ACT_PD, "power-down held");
        pd(4'h7, 1'b1, sdram_cmd_pkg::PWR_ACTIVE);
        do_cmd(4'h2, 3'h0, 16'h0400, 2'h0);
        pd(4'h7, 1'b0, sdram_cmd_pkg::PWR_PRE_PD);
        pd(4'hf, 1'b1, sdram_cmd_pkg::PWR_ACTIVE);
        check(idle, 1'b1, "idle after exit");
        pd(4'h1, 1'b0, sdram_cmd_pkg::PWR_SELF_REF);
        pd(4'hf, 1'b1, sdram_cmd_pkg::PWR_ACTIVE);
        do_cmd(4'h3, 3'h1, 16'h0042, 2'h0);
        // Mid-run reset away from any edge must clear at once
        #1;
        reset_n = 1'b0;
        #1;
        check(bank_open, 8'h00, "async clear");
        repeat (2) @(negedge ref_clk);
        check({last_cmd, pwr_state}, {sdram_cmd_pkg::CMD_DES, sdram_cmd_pkg::PWR_ACTIVE}, "held reset");
        reset_n = 1'b1;
        m_open = 8'h00;
        repeat (8) @(negedge ref_clk);
        do_cmd(4'h3, 3'h4, 16'h0055, 2'h0);
        end_sim();
    end

    // Run needs under 3000 cycles; the watchdog allows far more
    initial begin
        #100000;
        errors++;
        end_sim();
    end
endmodule
`default_nettype wire

// *** tb/sdram_ctrl_model.sv ***
// Purpose: Controller model driving the command pins of the decoder
// Assumes: Pins change on the falling edge of ref_clk
// Notes: Lines that no command qualifies carry a pattern that flips every cycle
`timescale 1ns/100ps
`default_nettype none
module sdram_ctrl_model (
    // Clock
    input wire logic ref_clk,
    // Command pins towards the device
    output var sdram_cmd_pkg::cmd_pins_type pins
);
    logic [3:0] cmd_r = 4'h7;
    logic cke_r = 1'b1;
    logic hold_r = 1'b0;
    logic [18:0] qual_r = 19'h00000;
    logic [1:0] dm_r = 2'h0;
    logic [18:0] noise_r = 19'h5a5a5;

    // Stale address values must never look valid to the decoder
    always @(negedge ref_clk) begin
        noise_r <= ~noise_r;
    end

    // Nop strobes between commands, noise on bank and address
    assign pins = {cmd_r, cke_r, hold_r ? qual_r : noise_r, dm_r};

    // One command held two edges, then nop; clock enable stays until the next call
    task automatic send(input logic [3:0] cmd, input logic cke, input logic [2:0] ba,
                        input logic [15:0] addr, input logic [1:0] dm);
        @(negedge ref_clk);
        cmd_r = cmd;
        cke_r = cke;
        qual_r = {ba, addr};
        dm_r = dm;
        hold_r = 1'b1;
        repeat (2) @(negedge ref_clk);
        cmd_r = 4'h7;
        hold_r = 1'b0;
    endtask
endmodule
`default_nettype wire
